// ---- plot_pkg.sv ----
// Constants and types shared by the plot command interpreter
package plot_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Stream codes
  localparam logic [7:0] CODE_PLOT_ENTRY = 8'h02; // Enters plot mode
  localparam logic [7:0] CODE_ESCAPE = 8'hFF;     // Leaves plot mode
  localparam logic [7:0] CODE_CHAR_PLOT = 8'hFE;  // Character plot submode
  localparam logic [7:0] CODE_X_POINT = 8'hFD;    // X point submode
  localparam logic [7:0] CODE_Y_POINT = 8'hFC;    // Y point submode
  localparam logic [7:0] CODE_XY_INC = 8'hFB;     // Incremental point submode
  localparam logic [7:0] CODE_BAR_START = 8'hFA;  // Bar start column submode
  localparam logic [7:0] CODE_BAR_ROW = 8'hF9;    // Bar row submode
  localparam logic [7:0] CODE_BAR_END = 8'hF8;    // Bar end column submode
  localparam logic [7:0] CODE_BAR_INC = 8'hF7;    // Incremental bar submode
  localparam logic [7:0] CODE_FIRST = 8'hF0;      // Lowest submode code

  ////////////////////////////////////////////////////////////////////////////
  // Step field encodings
  localparam logic [1:0] STEP_DEC = 2'h1; // Decrement by one
  localparam logic [1:0] STEP_INC = 2'h2; // Increment by one

  ////////////////////////////////////////////////////////////////////////////
  // Grid geometry
  localparam int COORD_W = 7;                       // 128 blocks per axis
  localparam logic [6:0] COORD_ONE = 7'h01;         // Unit step
  localparam logic [4:0] CELL_ROW_TOP = 5'h1F;      // Highest cell row index
  localparam logic [7:0] CELL_BIT_ONE = 8'h01;      // Mask seed
  localparam logic [3:0] NIBBLE_ZERO = 4'h0;        // Invisible move marker
  localparam logic [7:0] RESET_BYTE = 8'h00;        // Cleared byte value

  ////////////////////////////////////////////////////////////////////////////
  // Submode and work states
  typedef enum logic [3:0] {
    M_OFF = 4'h0,
    M_X_POINT = 4'h1,
    M_Y_POINT = 4'h2,
    M_XY_INC = 4'h3,
    M_BAR_START = 4'h4,
    M_BAR_ROW = 4'h5,
    M_BAR_END = 4'h6,
    M_BAR_INC = 4'h7,
    M_CHAR = 4'h8,
    M_OTHER = 4'h9
  } mode_t;

  typedef enum logic [2:0] {
    W_IDLE = 3'h0,
    W_STEP1 = 3'h1,
    W_STEP2 = 3'h2,
    W_BSTEP1 = 3'h3,
    W_BSTEP2 = 3'h4,
    W_BAR = 3'h5
  } work_t;

endpackage : plot_pkg

// ---- plot_interp.sv ----
// Plot mode byte interpreter: point, incremental point and horizontal bar submodes
`timescale 1ns/1ps
`default_nettype none

module plot_interp (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // Command byte stream
  input wire logic i_byte_valid,
  input wire logic [7:0] i_byte,
  output logic o_ready,
  // Attributes sampled at plot mode entry
  input wire logic i_erase_flag,
  input wire logic [7:0] i_colour,
  // Block write to the display
  output logic o_blk_valid,
  output logic [6:0] o_blk_x,
  output logic [6:0] o_blk_y,
  output logic o_blk_toggle,
  output logic [7:0] o_blk_colour,
  output logic [5:0] o_cell_col,
  output logic [4:0] o_cell_row,
  output logic [7:0] o_cell_mask,
  // Status
  output logic o_plot_mode
);

  ////////////////////////////////////////////////////////////////////////////
  // Functions

  // step field decode; 0 and 3 hold, edges wrap
  function automatic logic [6:0] step(input logic [6:0] c, input logic [1:0] f);
    logic [6:0] r;
    r = c;
    if (f == plot_pkg::STEP_DEC)
      r = c - plot_pkg::COORD_ONE;
    else if (f == plot_pkg::STEP_INC)
      r = c + plot_pkg::COORD_ONE;
    return r;
  endfunction : step

  // Submode selected by a code byte
  function automatic plot_pkg::mode_t mode_of(input logic [7:0] code);
    plot_pkg::mode_t m;
    case (code)
      plot_pkg::CODE_CHAR_PLOT: m = plot_pkg::M_CHAR;
      plot_pkg::CODE_X_POINT: m = plot_pkg::M_X_POINT;
      plot_pkg::CODE_Y_POINT: m = plot_pkg::M_Y_POINT;
      plot_pkg::CODE_XY_INC: m = plot_pkg::M_XY_INC;
      plot_pkg::CODE_BAR_START: m = plot_pkg::M_BAR_START;
      plot_pkg::CODE_BAR_ROW: m = plot_pkg::M_BAR_ROW;
      plot_pkg::CODE_BAR_END: m = plot_pkg::M_BAR_END;
      plot_pkg::CODE_BAR_INC: m = plot_pkg::M_BAR_INC;
      default: m = plot_pkg::M_OTHER;
    endcase
    return m;
  endfunction : mode_of

  // Bit of the cell pattern for a block; bits 0-3 left column top down
  function automatic logic [7:0] cell_bit(input logic [6:0] x, input logic [6:0] y);
    return plot_pkg::CELL_BIT_ONE << {x[0], ~y[1:0]};
  endfunction : cell_bit

  ////////////////////////////////////////////////////////////////////////////
  // State
  plot_pkg::mode_t mode_r, mode_nxt;     // Current submode
  plot_pkg::work_t work_r, work_nxt;     // Multi-cycle drawing step
  logic [6:0] x_r, x_nxt;                // Point cursor X
  logic [6:0] y_r, y_nxt;                // Point cursor Y
  logic [6:0] bar_start_column_r, bar_start_column_nxt;
  logic [6:0] row_r, row_nxt;            // Bar row
  logic [6:0] end_r, end_nxt;            // Bar end column
  logic [6:0] draw_r, draw_nxt;          // Column being drawn
  logic [7:0] inc_r, inc_nxt;            // Held increment byte
  logic second_r, second_nxt;            // Second bar still pending
  logic toggle_r, toggle_nxt;            // Erase flag caught at entry
  logic [7:0] colour_r, colour_nxt;      // Colour caught at entry
  logic ready_r;
  logic fire;                            // Block write this cycle
  logic [6:0] fx, fy;                    // Block write coordinates

  ////////////////////////////////////////////////////////////////////////////
  // Decoding
  wire take = i_byte_valid && ready_r;
  wire is_code = i_byte >= plot_pkg::CODE_FIRST;
  wire [6:0] data7 = i_byte[6:0];
  wire [6:0] sx1 = step(x_r, inc_r[7:6]);
  wire [6:0] sy1 = step(y_r, inc_r[5:4]);
  wire [6:0] sx2 = step(x_r, inc_r[3:2]);
  wire [6:0] sy2 = step(y_r, inc_r[1:0]);
  wire [6:0] be1 = step(end_r, inc_r[7:6]);
  wire [6:0] br1 = step(row_r, inc_r[5:4]);
  wire [6:0] be2 = step(end_r, inc_r[3:2]);
  wire [6:0] br2 = step(row_r, inc_r[1:0]);
  // Bars are drawn left to right whichever end is larger
  wire [6:0] bar_hi = (end_r > bar_start_column_r) ? end_r : bar_start_column_r;

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb
  begin
    mode_nxt = mode_r;
    work_nxt = work_r;
    x_nxt = x_r;
    y_nxt = y_r;
    bar_start_column_nxt = bar_start_column_r;
    row_nxt = row_r;
    end_nxt = end_r;
    draw_nxt = draw_r;
    inc_nxt = inc_r;
    second_nxt = second_r;
    toggle_nxt = toggle_r;
    colour_nxt = colour_r;
    fire = 1'b0;
    fx = x_r;
    fy = y_r;
    case (work_r)
      plot_pkg::W_IDLE:
      begin
        if (!take)
        begin
          // Nothing to do
        end
        else if (mode_r == plot_pkg::M_OFF)
        begin
          if (i_byte == plot_pkg::CODE_PLOT_ENTRY)
          begin
            mode_nxt = plot_pkg::M_X_POINT;
            toggle_nxt = i_erase_flag;
            // colour is the one current at entry
            colour_nxt = i_colour;
          end
        end
        else if (i_byte == plot_pkg::CODE_ESCAPE)
          mode_nxt = plot_pkg::M_OFF;
        else if (mode_r == plot_pkg::M_CHAR)
        begin
          // character plot leaves only by escape
        end
        else if (is_code)
          mode_nxt = mode_of(i_byte);
        else
        begin
          case (mode_r)
            plot_pkg::M_X_POINT:
            begin
              // X only stored, no block set
              x_nxt = data7;
              mode_nxt = plot_pkg::M_Y_POINT;
            end
            plot_pkg::M_Y_POINT:
            begin
              y_nxt = data7;
              fire = 1'b1;
              fy = data7;
              mode_nxt = plot_pkg::M_X_POINT;
            end
            plot_pkg::M_XY_INC:
            begin
              inc_nxt = i_byte;
              work_nxt = plot_pkg::W_STEP1;
            end
            plot_pkg::M_BAR_START:
            begin
              bar_start_column_nxt = data7;
              mode_nxt = plot_pkg::M_BAR_ROW;
            end
            plot_pkg::M_BAR_ROW:
            begin
              row_nxt = data7;
              mode_nxt = plot_pkg::M_BAR_END;
            end
            plot_pkg::M_BAR_END:
            begin
              // draw bar, then back to row
              end_nxt = data7;
              draw_nxt = (data7 < bar_start_column_r) ? data7 : bar_start_column_r;
              work_nxt = plot_pkg::W_BAR;
              mode_nxt = plot_pkg::M_BAR_ROW;
            end
            plot_pkg::M_BAR_INC:
            begin
              inc_nxt = i_byte;
              work_nxt = plot_pkg::W_BSTEP1;
            end
            default:
            begin
              // Submodes handled elsewhere swallow data
            end
          endcase
        end
      end
      plot_pkg::W_STEP1:
      begin
        x_nxt = sx1;
        y_nxt = sy1;
        fx = sx1;
        fy = sy1;
        if (inc_r[3:0] == plot_pkg::NIBBLE_ZERO)
          work_nxt = plot_pkg::W_IDLE;
        else
        begin
          fire = 1'b1;
          work_nxt = plot_pkg::W_STEP2;
        end
      end
      plot_pkg::W_STEP2:
      begin
        x_nxt = sx2;
        y_nxt = sy2;
        fx = sx2;
        fy = sy2;
        fire = 1'b1;
        work_nxt = plot_pkg::W_IDLE;
      end
      plot_pkg::W_BSTEP1:
      begin
        // first bar moved by upper nibble
        end_nxt = be1;
        row_nxt = br1;
        draw_nxt = (be1 < bar_start_column_r) ? be1 : bar_start_column_r;
        second_nxt = 1'b1;
        work_nxt = plot_pkg::W_BAR;
      end
      plot_pkg::W_BSTEP2:
      begin
        // second bar moved by lower nibble
        end_nxt = be2;
        row_nxt = br2;
        draw_nxt = (be2 < bar_start_column_r) ? be2 : bar_start_column_r;
        work_nxt = plot_pkg::W_BAR;
      end
      plot_pkg::W_BAR:
      begin
        // one block per column on a single row
        fire = 1'b1;
        fx = draw_r;
        fy = row_r;
        if (draw_r != bar_hi)
          draw_nxt = draw_r + plot_pkg::COORD_ONE;
        else if (second_r)
        begin
          second_nxt = 1'b0;
          work_nxt = plot_pkg::W_BSTEP2;
        end
        else
          work_nxt = plot_pkg::W_IDLE;
      end
      default:
        work_nxt = plot_pkg::W_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control registers
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      mode_r <= plot_pkg::M_OFF;
      work_r <= plot_pkg::W_IDLE;
      second_r <= 1'b0;
      ready_r <= 1'b0;
      o_plot_mode <= 1'b0;
    end
    else
    begin
      mode_r <= mode_nxt;
      work_r <= work_nxt;
      second_r <= second_nxt;
      // Stall the source while a bar or step pair is drawn
      ready_r <= (work_nxt == plot_pkg::W_IDLE);
      o_plot_mode <= (mode_nxt != plot_pkg::M_OFF);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Coordinate registers
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      x_r <= '0;
      y_r <= '0;
      bar_start_column_r <= '0;
      row_r <= '0;
      end_r <= '0;
      draw_r <= '0;
      inc_r <= plot_pkg::RESET_BYTE;
      toggle_r <= 1'b0;
      colour_r <= plot_pkg::RESET_BYTE;
    end
    else
    begin
      x_r <= x_nxt;
      y_r <= y_nxt;
      // never cleared on leaving plot mode
      bar_start_column_r <= bar_start_column_nxt;
      row_r <= row_nxt;
      end_r <= end_nxt;
      draw_r <= draw_nxt;
      inc_r <= inc_nxt;
      toggle_r <= toggle_nxt;
      colour_r <= colour_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Block write outputs
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      o_blk_valid <= 1'b0;
      o_blk_x <= '0;
      o_blk_y <= '0;
      o_blk_toggle <= 1'b0;
      o_blk_colour <= plot_pkg::RESET_BYTE;
      o_cell_col <= '0;
      o_cell_row <= '0;
      o_cell_mask <= plot_pkg::RESET_BYTE;
    end
    else
    begin
      o_blk_valid <= fire;
      o_blk_x <= fx;
      o_blk_y <= fy;
      o_blk_toggle <= toggle_r;
      o_blk_colour <= colour_r;
      // Y counts up from the bottom, cell rows count down
      o_cell_col <= fx[6:1];
      o_cell_row <= plot_pkg::CELL_ROW_TOP - fy[6:2];
      // mask overwrites any text in the cell
      o_cell_mask <= cell_bit(fx, fy);
    end
  end

  assign o_ready = ready_r;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);

  a_entry_x_point: assert property (
    take && mode_r == plot_pkg::M_OFF && i_byte == plot_pkg::CODE_PLOT_ENTRY
    |=> mode_r == plot_pkg::M_X_POINT && o_plot_mode)
    else $error("entry code did not select X point");
  a_x_fold: assert property (
    take && mode_r == plot_pkg::M_X_POINT && !is_code |=> x_r == $past(i_byte[6:0]))
    else $error("X value not folded into 0..127");
  a_escape_exit: assert property (
    take && mode_r != plot_pkg::M_OFF && i_byte == plot_pkg::CODE_ESCAPE
    |=> mode_r == plot_pkg::M_OFF && !o_plot_mode)
    else $error("escape did not leave plot mode");
  a_x_no_plot: assert property (
    take && mode_r == plot_pkg::M_X_POINT && !is_code
    |=> !o_blk_valid && mode_r == plot_pkg::M_Y_POINT)
    else $error("X value plotted or did not move to Y");
  a_y_plots: assert property (
    take && mode_r == plot_pkg::M_Y_POINT && !is_code
    |=> o_blk_valid && o_blk_y == $past(i_byte[6:0]) && o_blk_x == $past(x_r)
        && mode_r == plot_pkg::M_X_POINT)
    else $error("Y value did not plot at stored X");
  a_invisible_move: assert property (
    work_r == plot_pkg::W_STEP1 && inc_r[3:0] == plot_pkg::NIBBLE_ZERO
    |=> !o_blk_valid && o_ready)
    else $error("invisible move set a block");
  a_bar_row: assert property (
    work_r == plot_pkg::W_BAR |=> o_blk_valid && o_blk_y == $past(row_r) && o_blk_x == $past(draw_r)
        && (o_ready == $past(draw_r == bar_hi && !second_r)))
    else $error("bar block off its row");
  a_start_kept: assert property (
    mode_r == plot_pkg::M_OFF |=> bar_start_column_r == $past(bar_start_column_r))
    else $error("start column lost outside plot mode");
  a_cell_onehot: assert property (
    o_blk_valid |-> $onehot(o_cell_mask))
    else $error("cell mask not one block");

  c_point_plot: cover property (take && mode_r == plot_pkg::M_Y_POINT && !is_code);
  c_invisible: cover property (work_r == plot_pkg::W_STEP1 && inc_r[3:0] == plot_pkg::NIBBLE_ZERO);
  c_bar_done: cover property (work_r == plot_pkg::W_BAR && draw_r == bar_hi && !second_r);
  c_inc_bar: cover property (work_r == plot_pkg::W_BSTEP2);

endmodule : plot_interp

`default_nettype wire

// ---- plot_host.sv ----
// Host model that feeds command and data bytes to the plot interpreter
`timescale 1ns/1ps
`default_nettype none

module plot_host (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // Pacing and handshake
  input wire logic i_slow,
  input wire logic i_ready,
  // Byte offer
  output logic o_byte_valid,
  output logic [7:0] o_byte,
  output logic o_idle
);
  logic [7:0] pend_q [$]; // Bytes waiting to be offered
  logic taken;            // Offer accepted at the last rising edge
  int gap;                // Idle cycles still owed in slow pacing

  initial
  begin
    o_byte_valid = 1'b0;
    o_byte = 8'h00;
    o_idle = 1'b1;
    taken = 1'b0;
    gap = 0;
  end

  // Queue a byte; the bench calls this at a falling edge
  task automatic push(input logic [7:0] b);
    pend_q.push_back(b);
  endtask : push

  ////////////////////////////////////////////////////////////////////////////
  // Note whether the interpreter took the byte on offer
  always @(posedge i_clk)
    taken <= o_byte_valid & i_ready;

  // Offer, hold or release; a released line flips every cycle so a stale byte never passes as fresh
  always @(negedge i_clk)
  begin
    if (taken)
      gap = i_slow ? 3 : 0;
    if (o_byte_valid && !taken)
      o_byte_valid = 1'b1;
    // increment bytes stay below 240, codes at 240 and above
    else if (gap == 0 && pend_q.size() > 0 && !i_reset)
    begin
      o_byte_valid = 1'b1;
      o_byte = pend_q.pop_front();
    end
    else
    begin
      o_byte_valid = 1'b0;
      o_byte = ~o_byte;
      if (gap > 0)
        gap--;
    end
    o_idle = !o_byte_valid && pend_q.size() == 0;
  end
endmodule : plot_host

`default_nettype wire

// ---- plot_point_and_xbar_interpreter_bench.sv ----
// Self-checking bench for the plot point and horizontal bar interpreter
`timescale 1ns/1ps
`default_nettype none

module plot_point_and_xbar_interpreter_bench;
  logic i_clk;             // System clock
  logic i_reset;           // Synchronous reset
  logic i_slow;            // Host pacing select
  logic i_erase_flag;      // Toggle plotting select
  logic [7:0] i_colour;    // Colour sampled at entry
  logic byte_valid;        // Host byte offer
  logic [7:0] byte_data;   // Host byte
  logic host_idle;         // Host queue drained
  logic o_ready;           // Interpreter can take a byte
  logic blk_valid;         // Block write pulse
  logic [6:0] blk_x;       // Block column
  logic [6:0] blk_y;       // Block row
  logic blk_toggle;        // XOR write
  logic [7:0] blk_colour;  // Block colour
  logic [5:0] cell_col;    // Cell column
  logic [4:0] cell_row;    // Cell row
  logic [7:0] cell_mask;   // Block bit in cell
  logic plot_mode;         // Plot mode status
  logic [13:0] seen [$];   // Blocks written, {y, x}
  logic cur_erase;         // Expected toggle flag
  logic [7:0] cur_colour;  // Expected colour
  int fail_count;          // Mismatches
  int n_compared;          // Comparisons made

  // Rows: ten bytes first to last, then up to five segments {y, x_a, x_b} first to last, then segment count
  logic [79:0] row_in [10] = '{
    80'h02050A868FFF00000000, 80'h027F7F0000FF00000000, 80'h021020FB92603CFF0000,
    80'h020000FB500AFF000000, 80'h02FA850907FF00000000, 80'h02F90B040C05FF000000,
    80'h0221FC30F90DF806FF00, 80'h02FEFD0506FF00000000, 80'h02F00506FD0708FF0000,
    80'h02FA03F90A06F7A1FF00};
  logic [119:0] row_seg [10] = '{
    120'h0A05050F0606, 120'h7F7F7F000000, 120'h2010101F1111201111211010211010,
    120'h0000007F7F7F000000, 120'h090507, 120'h0B04050C0505,
    120'h3021210D0506, 120'h000000, 120'h080707,
    120'h0A03060B03070A0307};
  logic [3:0] row_n [10] = '{4'h2, 4'h2, 4'h5, 4'h3, 4'h1, 4'h2, 4'h2, 4'h0, 4'h1, 4'h3};

  ////////////////////////////////////////////////////////////////////////////
  // Clock at 100 MHz
  initial
  begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end

  plot_host i_host (.i_clk(i_clk), .i_reset(i_reset), .i_slow(i_slow), .i_ready(o_ready),
    .o_byte_valid(byte_valid), .o_byte(byte_data), .o_idle(host_idle));

  plot_interp i_dut (.i_clk(i_clk), .i_reset(i_reset), .i_byte_valid(byte_valid), .i_byte(byte_data),
    .o_ready(o_ready), .i_erase_flag(i_erase_flag), .i_colour(i_colour), .o_blk_valid(blk_valid),
    .o_blk_x(blk_x), .o_blk_y(blk_y), .o_blk_toggle(blk_toggle), .o_blk_colour(blk_colour),
    .o_cell_col(cell_col), .o_cell_row(cell_row), .o_cell_mask(cell_mask), .o_plot_mode(plot_mode));

  ////////////////////////////////////////////////////////////////////////////
  // Compare tasks and the closing task
  task automatic check_bit(input string what, input logic exp, input logic got);
    n_compared++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[FAIL] %s expected %b seen %b", what, exp, got);
    end
  endtask : check_bit

  task automatic check_val(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : check_val

  task automatic print_verdict();
    if (fail_count == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : print_verdict

  ////////////////////////////////////////////////////////////////////////////
  // Block monitor: each pulse is logged, and its cell fields are worked out from x and y
  always @(negedge i_clk)
  begin
    if (blk_valid === 1'b1)
    begin
      seen.push_back({blk_y, blk_x});
      check_bit("toggle", cur_erase, blk_toggle);
      check_val("colour", {8'h00, cur_colour}, {8'h00, blk_colour});
      check_val("cell_col", {10'h000, blk_x[6:1]}, {10'h000, cell_col});
      check_val("cell_row", {11'h000, 5'h1F - blk_y[6:2]}, {11'h000, cell_row});
      check_val("cell_mask", {8'h00, 8'h01 << {blk_x[0], 2'h3 - blk_y[1:0]}}, {8'h00, cell_mask});
    end
  end

  // Wait for the host to drain and the interpreter to finish drawing, bounded
  task automatic wait_done();
    int t;
    t = 0;
    repeat (2) @(negedge i_clk);
    while (host_idle !== 1'b1 && t < 2000)
    begin
      @(negedge i_clk);
      t++;
    end
    repeat (2) @(negedge i_clk);
    while (o_ready !== 1'b1 && t < 2000)
    begin
      @(negedge i_clk);
      t++;
    end
    repeat (3) @(negedge i_clk);
    check_bit("finished", 1'b1, t < 2000);
  endtask : wait_done

  // Send one row and compare the blocks drawn, bars expanded from the lower column up
  task automatic run_row(input int r);
    logic [23:0] s;
    int k;
    int x;
    int idx;
    int lo;
    int hi;
    cur_colour = 8'h40 + r[7:0];
    cur_erase = r[0];
    i_colour = cur_colour;
    i_erase_flag = cur_erase;
    seen.delete();
    for (k = 0; k < 10; k++)
      i_host.push(row_in[r][8 * (9 - k) +: 8]);
    wait_done();
    idx = 0;
    for (k = 0; k < row_n[r]; k++)
    begin
      s = row_seg[r][24 * (row_n[r] - 1 - k) +: 24];
      lo = (s[15:8] < s[7:0]) ? s[15:8] : s[7:0];
      hi = (s[15:8] < s[7:0]) ? s[7:0] : s[15:8];
      for (x = lo; x <= hi; x++)
      begin
        if (idx < seen.size())
          check_val("block", {2'h0, s[22:16], x[6:0]}, {2'h0, seen[idx]});
        idx++;
      end
    end
    // Every bar block counts, not just one per segment
    check_val("block_count", 16'(idx), 16'(seen.size()));
    check_bit("mode_after_escape", 1'b0, plot_mode);
  endtask : run_row

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    i_reset = 1'b1;
    i_slow = 1'b0;
    i_erase_flag = 1'b0;
    i_colour = 8'h00;
    cur_erase = 1'b0;
    cur_colour = 8'h00;
    fail_count = 0;
    n_compared = 0;
    repeat (3) @(negedge i_clk);
    check_bit("ready_in_reset", 1'b0, o_ready);
    check_bit("mode_in_reset", 1'b0, plot_mode);
    check_bit("blk_in_reset", 1'b0, blk_valid);
    i_reset = 1'b0;
    repeat (2) @(negedge i_clk);
    check_bit("ready_after_reset", 1'b1, o_ready);
    // Table twice: host back to back, then slow host
    for (int p = 0; p < 2; p++)
    begin
      i_slow = p[0];
      for (int r = 0; r < 10; r++)
        run_row(r);
    end
    // Entry code alone raises plot mode, X data plots nothing
    seen.delete();
    i_host.push(8'h02);
    i_host.push(8'h05);
    wait_done();
    check_bit("mode_on", 1'b1, plot_mode);
    check_val("x_only", 16'h0000, 16'(seen.size()));
    // Reset in mid plot drops plot mode; later data is ignored
    i_reset = 1'b1;
    repeat (3) @(negedge i_clk);
    i_reset = 1'b0;
    repeat (2) @(negedge i_clk);
    check_bit("mode_after_reset", 1'b0, plot_mode);
    i_host.push(8'h06);
    i_host.push(8'h07);
    wait_done();
    check_val("blocks_outside", 16'h0000, 16'(seen.size()));
    print_verdict();
  end

  // Watchdog, well beyond the expected run of under a thousand cycles
  initial
  begin
    #300000;
    fail_count++;
    $display("[FAIL] watchdog expected done seen hang");
    print_verdict();
  end
endmodule : plot_point_and_xbar_interpreter_bench

`default_nettype wire
